// ---- design/dsp_glue_pkg.sv ----
// constants for the signal-processor system glue: maps, registers, timing
package dsp_glue_pkg;
  // timing
  localparam int REF_CLK_NS    = 25;
  localparam int ICYC_NS       = 50;
  localparam int REF_PER_ICYC  = ICYC_NS / REF_CLK_NS;
  localparam int POR_HOLD_ICYC = 65536;
  // interrupt sources
  localparam int NUM_CORE_IRQ  = 5;
  localparam int NUM_PER_IRQ   = 11;
  localparam int NUM_IRQ       = NUM_CORE_IRQ + NUM_PER_IRQ;
  // program memory map
  localparam logic [13:0] PM_VEC_HI  = 14'h002F;
  localparam logic [13:0] PM_RAM_HI  = 14'h01FF;
  localparam logic [13:0] PM_ROM_LO  = 14'h0800;
  localparam logic [13:0] PM_ROM_HI  = 14'h17FF;
  localparam logic [13:0] BOOT_ADDR  = PM_ROM_LO;
  // data memory map
  localparam logic [13:0] DM_PER_LO  = 14'h2000;
  localparam logic [13:0] DM_PER_HI  = 14'h20FF;
  localparam logic [13:0] DM_RAM_LO  = 14'h3800;
  localparam logic [13:0] DM_RAM_HI  = 14'h39FF;
  localparam logic [13:0] DM_CORE_LO = 14'h3C00;
  // core control registers
  localparam logic [13:0] SYS_CTL_ADDR  = 14'h3FFF;
  localparam logic [13:0] WAIT_ADDR     = 14'h3FFE;
  localparam logic [13:0] IRQ_MASK_ADDR = 14'h3FFD;
  localparam logic [13:0] IRQ_STAT_ADDR = 14'h3FFC;
  localparam logic [13:0] MODE_CTL_ADDR = 14'h3FFB;
  localparam int          SPORT_EN_BIT  = 10;
  localparam int          RX_SEL_BIT    = 0;
  localparam logic [15:0] SYS_CTL_RST   = 16'h0000;
  localparam logic [15:0] WAIT_RST      = 16'hFFFF;
  localparam logic [15:0] MASK_RST      = 16'h0000;
  localparam logic [15:0] MODE_RST      = 16'h0000;
  typedef enum logic [1:0] {SRC_NONE, SRC_RAM, SRC_REG, SRC_EXT} rd_src_t;
endpackage

// ---- design/dsp_system_glue.sv ----
// system glue: address decode, interrupt funnel, clock, reset sequencing
//
// Summary of operation
// - sixteen interrupt sources: five core, eleven peripheral
// - peripheral sources: nine I/O, PWM sync, trip
// - peripheral interrupts merged onto one core line
// - fixed priority, one mask bit per source
// - 512x24 program RAM from address zero
// - 4K program ROM at 0x0800 through 0x17FF
// - vector table in low RAM; reserved gaps
// - 512x16 data RAM 0x3800-0x39FF; gap reserved
// - peripheral and core register regions decoded
// - instruction clock half input rate, shown on output
// - hold reset 65536 cycles after supply good
// - reset whenever supply below threshold
// - low external reset pin resets everything
// - reset empties stacks, masks, clears mode status
// - fetch starts at ROM 0x0800 after reset
// - system control bit 10 selects serial port
// - wait state register resets to 0xFFFF
// - mode control bit selects receive data pin
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dsp_system_glue #(
  parameter int POR_HOLD_ICYC = dsp_glue_pkg::POR_HOLD_ICYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        supply_ok_i,
  input  wire logic        reset_n_pin_i,
  input  wire logic        instruction_clock_out_enable_i,
  output logic             instruction_clock_out_o,
  output logic             sys_reset_o,
  output logic             stack_empty_o,
  output logic             core_mode_status_clear_o,
  output logic             fetch_start_o,
  output logic [13:0]      fetch_addr_o,
  input  wire logic [13:0] pm_addr_i,
  input  wire logic        pm_wr_i,
  input  wire logic        pm_rd_i,
  input  wire logic [23:0] pm_wdata_i,
  output logic [23:0]      pm_rdata_o,
  output logic [11:0]      rom_addr_o,
  input  wire logic [23:0] rom_rdata_i,
  input  wire logic [13:0] dm_addr_i,
  input  wire logic        dm_wr_i,
  input  wire logic        dm_rd_i,
  input  wire logic [15:0] dm_wdata_i,
  output logic [15:0]      dm_rdata_o,
  output logic [7:0]       periph_addr_o,
  output logic             periph_wr_o,
  output logic             periph_rd_o,
  output logic [15:0]      periph_wdata_o,
  input  wire logic [15:0] periph_rdata_i,
  input  wire logic [4:0]  core_irq_src_i,
  input  wire logic [8:0]  pio_irq_i,
  input  wire logic        pwm_period_sync_pulse_i,
  input  wire logic        pwm_shutdown_input_i,
  input  wire logic        sport_pin_a_i,
  input  wire logic        sport_pin_b_i,
  input  wire logic        rx_pin_a_i,
  input  wire logic        rx_pin_b_i,
  output logic             serial_port_enable_o,
  output logic             external_irq_a_o,
  output logic             external_irq_b_o,
  output logic             serial_receive_input_o,
  output logic             peripheral_irq_line_o,
  output logic             irq_req_o,
  output logic [3:0]       irq_id_o
);
  localparam int DIVW = (dsp_glue_pkg::REF_PER_ICYC > 2) ?
                        $clog2(dsp_glue_pkg::REF_PER_ICYC) : 1;
  localparam logic [DIVW-1:0] DIV_LAST =
    DIVW'(dsp_glue_pkg::REF_PER_ICYC - 1);
  localparam logic [16:0] POR_LAST = 17'(POR_HOLD_ICYC - 1);

  typedef struct packed {
    logic [DIVW-1:0]      div;
    logic                 clk_ph;
    logic [16:0]          por_cnt;
    logic                 por_done;
    logic                 sys_rst;
    logic                 fetch_start;
    logic [15:0]          sys_ctl;
    logic [15:0]          wait_ctl;
    logic [15:0]          irq_mask;
    logic [15:0]          mode_ctl;
    logic [15:0]          reg_q;
    logic [23:0]          rom_q;
    dsp_glue_pkg::rd_src_t dm_src;
    dsp_glue_pkg::rd_src_t pm_src;
    logic                 irq_req;
    logic [3:0]           irq_id;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [23:0] pm_ram [0:511];
  logic [15:0] dm_ram [0:511];
  logic [23:0] pm_ram_q;
  logic [15:0] dm_ram_q;

  logic        tick;
  logic        pm_in_ram;
  logic        pm_in_rom;
  logic        dm_in_ram;
  logic        dm_in_per;
  logic        dm_in_core;
  logic        pm_ram_we;
  logic        dm_ram_we;
  logic [15:0] irq_src;
  logic [15:0] irq_pend;

  assign tick = (st_reg.div == DIV_LAST);

  // program decode; vectors sit in the first 0x30 RAM words
  assign pm_in_ram = (pm_addr_i <= dsp_glue_pkg::PM_RAM_HI);
  assign pm_in_rom = (pm_addr_i >= dsp_glue_pkg::PM_ROM_LO) &&
                     (pm_addr_i <= dsp_glue_pkg::PM_ROM_HI);
  assign rom_addr_o = pm_addr_i[11:0] - dsp_glue_pkg::PM_ROM_LO[11:0];

  // data decode
  assign dm_in_ram  = (dm_addr_i >= dsp_glue_pkg::DM_RAM_LO) &&
                      (dm_addr_i <= dsp_glue_pkg::DM_RAM_HI);
  assign dm_in_per  = (dm_addr_i >= dsp_glue_pkg::DM_PER_LO) &&
                      (dm_addr_i <= dsp_glue_pkg::DM_PER_HI);
  assign dm_in_core = (dm_addr_i >= dsp_glue_pkg::DM_CORE_LO);

  // storage changes only inside mapped ranges and outside reset
  assign pm_ram_we = pm_wr_i && pm_in_ram && !st_reg.sys_rst;
  assign dm_ram_we = dm_wr_i && dm_in_ram && !st_reg.sys_rst;

  assign periph_addr_o  = dm_addr_i[7:0];
  assign periph_wr_o    = dm_wr_i && dm_in_per && !st_reg.sys_rst;
  assign periph_rd_o    = dm_rd_i && dm_in_per;
  assign periph_wdata_o = dm_wdata_i;

  // pins double as interrupt lines when the serial port is off
  assign serial_port_enable_o =
    st_reg.sys_ctl[dsp_glue_pkg::SPORT_EN_BIT];
  assign external_irq_a_o = !serial_port_enable_o && !sport_pin_a_i;
  assign external_irq_b_o = !serial_port_enable_o && !sport_pin_b_i;
  assign serial_receive_input_o =
    st_reg.mode_ctl[dsp_glue_pkg::RX_SEL_BIT] ?
    rx_pin_b_i : rx_pin_a_i;

  // sixteen sources: core 0..4, then I/O, sync, trip
  always_comb begin
    irq_src[4:0] = core_irq_src_i;
    if (!serial_port_enable_o) begin
      irq_src[0] = external_irq_a_o;
      irq_src[1] = external_irq_b_o;
    end
    irq_src[13:5] = pio_irq_i;
    irq_src[14]   = pwm_period_sync_pulse_i;
    irq_src[15]   = pwm_shutdown_input_i;
  end

  assign irq_pend = irq_src & st_reg.irq_mask;
  assign peripheral_irq_line_o = |irq_pend[15:5];

  always_comb begin
    st_next = st_reg;
    st_next.fetch_start = 1'b0;
    // instruction rate from the reference
    st_next.div = tick ? '0 : st_reg.div + 1'b1;
    st_next.clk_ph = (st_next.div == '0);
    // reset sequencing
    if (!supply_ok_i) begin
      st_next.por_cnt  = '0;
      st_next.por_done = 1'b0;
    end else if (!st_reg.por_done && tick) begin
      if (st_reg.por_cnt == POR_LAST) begin
        st_next.por_done = 1'b1;
      end else begin
        st_next.por_cnt = st_reg.por_cnt + 17'h0_0001;
      end
    end
    st_next.sys_rst = !supply_ok_i || !reset_n_pin_i ||
                      !st_next.por_done;
    if (st_reg.sys_rst && !st_next.sys_rst) begin
      st_next.fetch_start = 1'b1;
    end
    // fixed priority: lowest index wins
    st_next.irq_req = |irq_pend;
    st_next.irq_id  = '0;
    for (int i = dsp_glue_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_pend[i]) begin
        st_next.irq_id = 4'(i);
      end
    end
    // read source capture
    st_next.dm_src = dsp_glue_pkg::SRC_NONE;
    st_next.reg_q  = '0;
    if (dm_rd_i) begin
      if (dm_in_ram) begin
        st_next.dm_src = dsp_glue_pkg::SRC_RAM;
      end else if (dm_in_per) begin
        st_next.dm_src = dsp_glue_pkg::SRC_EXT;
      end else if (dm_in_core) begin
        st_next.dm_src = dsp_glue_pkg::SRC_REG;
        unique case (dm_addr_i)
          dsp_glue_pkg::SYS_CTL_ADDR:  st_next.reg_q = st_reg.sys_ctl;
          dsp_glue_pkg::WAIT_ADDR:     st_next.reg_q = st_reg.wait_ctl;
          dsp_glue_pkg::IRQ_MASK_ADDR: st_next.reg_q = st_reg.irq_mask;
          dsp_glue_pkg::IRQ_STAT_ADDR: st_next.reg_q = irq_src;
          dsp_glue_pkg::MODE_CTL_ADDR: st_next.reg_q = st_reg.mode_ctl;
          default:                     st_next.reg_q = '0;
        endcase
      end
    end
    st_next.pm_src = dsp_glue_pkg::SRC_NONE;
    st_next.rom_q  = '0;
    if (pm_rd_i && pm_in_ram) begin
      st_next.pm_src = dsp_glue_pkg::SRC_RAM;
    end else if (pm_rd_i && pm_in_rom) begin
      st_next.pm_src = dsp_glue_pkg::SRC_EXT;
      st_next.rom_q  = rom_rdata_i;
    end
    // register writes
    if (dm_wr_i && dm_in_core && !st_reg.sys_rst) begin
      unique case (dm_addr_i)
        dsp_glue_pkg::SYS_CTL_ADDR:  st_next.sys_ctl = dm_wdata_i;
        dsp_glue_pkg::WAIT_ADDR:     st_next.wait_ctl = dm_wdata_i;
        dsp_glue_pkg::IRQ_MASK_ADDR: st_next.irq_mask = dm_wdata_i;
        dsp_glue_pkg::MODE_CTL_ADDR: st_next.mode_ctl = dm_wdata_i;
        default: ;
      endcase
    end
    if (st_next.sys_rst) begin
      st_next.sys_ctl  = dsp_glue_pkg::SYS_CTL_RST;
      st_next.wait_ctl = dsp_glue_pkg::WAIT_RST;
      st_next.irq_mask = dsp_glue_pkg::MASK_RST;
      st_next.mode_ctl = dsp_glue_pkg::MODE_RST;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg          <= '0;
      st_reg.sys_rst  <= 1'b1;
      st_reg.wait_ctl <= dsp_glue_pkg::WAIT_RST;
      st_reg.dm_src   <= dsp_glue_pkg::SRC_NONE;
      st_reg.pm_src   <= dsp_glue_pkg::SRC_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (pm_ram_we) begin
      pm_ram[pm_addr_i[8:0]] <= pm_wdata_i;
    end
    if (dm_ram_we) begin
      dm_ram[dm_addr_i[8:0]] <= dm_wdata_i;
    end
    pm_ram_q <= pm_ram[pm_addr_i[8:0]];
    dm_ram_q <= dm_ram[dm_addr_i[8:0]];
  end

  always_comb begin
    dm_rdata_o = '0;
    pm_rdata_o = '0;
    unique case (st_reg.dm_src)
      dsp_glue_pkg::SRC_RAM:  dm_rdata_o = dm_ram_q;
      dsp_glue_pkg::SRC_REG:  dm_rdata_o = st_reg.reg_q;
      dsp_glue_pkg::SRC_EXT:  dm_rdata_o = periph_rdata_i;
      dsp_glue_pkg::SRC_NONE: dm_rdata_o = '0;
    endcase
    unique case (st_reg.pm_src)
      dsp_glue_pkg::SRC_RAM:  pm_rdata_o = pm_ram_q;
      dsp_glue_pkg::SRC_EXT:  pm_rdata_o = st_reg.rom_q;
      dsp_glue_pkg::SRC_REG,
      dsp_glue_pkg::SRC_NONE: pm_rdata_o = '0;
    endcase
  end

  assign instruction_clock_out_o = instruction_clock_out_enable_i && st_reg.clk_ph;
  assign sys_reset_o              = st_reg.sys_rst;
  assign stack_empty_o            = st_reg.sys_rst;
  assign core_mode_status_clear_o = st_reg.sys_rst;
  assign fetch_start_o            = st_reg.fetch_start;
  assign fetch_addr_o             = dsp_glue_pkg::BOOT_ADDR;
  assign irq_req_o                = st_reg.irq_req;
  assign irq_id_o                 = st_reg.irq_id;

  sequence seq_supply_up;
    $rose(supply_ok_i) && reset_n_pin_i;
  endsequence
  sequence seq_rst_release;
    $fell(sys_reset_o);
  endsequence

  chk_supply_low: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !supply_ok_i |=> sys_reset_o)
    else $error("reset not held while supply low");

  chk_pin_reset: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !reset_n_pin_i |=> sys_reset_o && stack_empty_o &&
    core_mode_status_clear_o)
    else $error("reset pin did not reset");

  chk_por_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    seq_supply_up |=> sys_reset_o [*8])
    else $error("reset released too early after supply rise");

  chk_boot_fetch: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    seq_rst_release |-> fetch_start_o && fetch_addr_o == 14'h0800
    ##1 !fetch_start_o)
    else $error("fetch did not start at rom base");

  chk_wait_default: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    seq_rst_release |-> st_reg.wait_ctl == 16'hFFFF)
    else $error("wait state register not at default");

  chk_reset_masks: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    sys_reset_o |-> st_reg.irq_mask == 16'h0000 ##1 !peripheral_irq_line_o
    || sys_reset_o)
    else $error("interrupts not masked in reset");

  chk_sport_bit: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    dm_wr_i && dm_addr_i == 14'h3FFF && !sys_reset_o && supply_ok_i
    && reset_n_pin_i |=> serial_port_enable_o == $past(dm_wdata_i[10]))
    else $error("serial port select not taken from bit 10");

  // the selection must follow the bit written, not merely the register
  chk_rx_select: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    dm_wr_i && dm_addr_i == dsp_glue_pkg::MODE_CTL_ADDR && !sys_reset_o
    && supply_ok_i && reset_n_pin_i
    |=> serial_receive_input_o ==
    ($past(dm_wdata_i[0]) ? rx_pin_b_i : rx_pin_a_i))
    else $error("receive pin mux wrong");

  chk_reserved_wr: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    dm_wr_i && dm_addr_i >= 14'h3A00 && dm_addr_i <= 14'h3BFF && !dm_rd_i
    |-> !dm_ram_we ##1 $stable(st_reg.sys_ctl) &&
    $stable(st_reg.irq_mask))
    else $error("reserved write changed a register");

  chk_reserved_rd: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    dm_rd_i && dm_addr_i >= 14'h2100 && dm_addr_i <= 14'h37FF
    |=> dm_rdata_o == 16'h0000)
    else $error("reserved read not harmless");

  chk_clk_toggle: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    instruction_clock_out_enable_i && $past(instruction_clock_out_enable_i)
    |-> instruction_clock_out_o != $past(instruction_clock_out_o))
    else $error("instruction clock not at half reference rate");

  chk_periph_funnel: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    pwm_shutdown_input_i && st_reg.irq_mask[15] && !(|irq_src[14:0])
    |=> irq_req_o && irq_id_o == 4'hF)
    else $error("trip interrupt not delivered at its priority");

  chk_rom_fetch: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    pm_rd_i && pm_in_rom |=> pm_rdata_o == $past(rom_rdata_i))
    else $error("rom word not returned after program read");

  // read data stands only in the cycle after its strobe
  chk_read_once: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !dm_rd_i ##1 !dm_rd_i |-> dm_rdata_o == 16'h0000)
    else $error("read data stood past its cycle");
endmodule // dsp_system_glue
`default_nettype wire

// ---- dv/glue_far_model.sv ----
// far-side model: program rom and peripheral register responder
`timescale 1ns/1ps
`default_nettype none
module glue_far_model (
  input  wire logic        clk_i,
  input  wire logic [11:0] rom_addr_i,
  input  wire logic [7:0]  periph_addr_i,
  input  wire logic        periph_rd_i,
  output logic [23:0]      rom_rdata_o,
  output logic [15:0]      periph_rdata_o
);
  logic       rd_reg;
  logic [7:0] ad_reg;
  // rom word carries its own offset so a wrong index shows
  assign rom_rdata_o = {12'h5A3, rom_addr_i};
  always_ff @(posedge clk_i) begin
    rd_reg <= periph_rd_i;
    ad_reg <= periph_addr_i;
  end
  // data only in the cycle after a read; inverted pattern otherwise
  assign periph_rdata_o = rd_reg ? {8'hC3, ad_reg} : {8'h3C, ~ad_reg};
endmodule // glue_far_model
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the system glue
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int HOLD = 16;
  logic        ck = 0, rst = 1, sup = 1, pin_n = 1, cke = 0;
  logic        pw = 0, pr = 0, dw = 0, dr = 0, psync = 0, ptrip = 0;
  logic        spa = 1, spb = 1, rxa = 0, rxb = 0;
  logic [13:0] pa = 0, da = 0, fad;
  logic [23:0] pwd = 0, prd, rrd;
  logic [15:0] dwd = 0, drd, xwd, xrd;
  logic [11:0] ra;
  logic [7:0]  xa;
  logic [4:0]  cirq = 0;
  logic [8:0]  pio = 0;
  logic [3:0]  iid;
  logic        ico, srst, stk, msc, fst, xw, xr, spen, eia, eib, rxo;
  logic        pirq, ireq;
  int          bad_count = 0, cmp_count = 0, cyc = 0;

  dsp_system_glue #(.POR_HOLD_ICYC(HOLD)) u_dsp_system_glue (
    .ref_clk_i(ck), .rst_i(rst), .supply_ok_i(sup),
    .reset_n_pin_i(pin_n), .instruction_clock_out_enable_i(cke),
    .instruction_clock_out_o(ico), .sys_reset_o(srst),
    .stack_empty_o(stk), .core_mode_status_clear_o(msc),
    .fetch_start_o(fst), .fetch_addr_o(fad),
    .pm_addr_i(pa), .pm_wr_i(pw), .pm_rd_i(pr), .pm_wdata_i(pwd),
    .pm_rdata_o(prd), .rom_addr_o(ra), .rom_rdata_i(rrd),
    .dm_addr_i(da), .dm_wr_i(dw), .dm_rd_i(dr), .dm_wdata_i(dwd),
    .dm_rdata_o(drd), .periph_addr_o(xa), .periph_wr_o(xw),
    .periph_rd_o(xr), .periph_wdata_o(xwd), .periph_rdata_i(xrd),
    .core_irq_src_i(cirq), .pio_irq_i(pio),
    .pwm_period_sync_pulse_i(psync), .pwm_shutdown_input_i(ptrip),
    .sport_pin_a_i(spa), .sport_pin_b_i(spb),
    .rx_pin_a_i(rxa), .rx_pin_b_i(rxb),
    .serial_port_enable_o(spen), .external_irq_a_o(eia),
    .external_irq_b_o(eib), .serial_receive_input_o(rxo),
    .peripheral_irq_line_o(pirq), .irq_req_o(ireq), .irq_id_o(iid));

  glue_far_model u_glue_far_model (
    .clk_i(ck), .rom_addr_i(ra), .periph_addr_i(xa),
    .periph_rd_i(xr), .rom_rdata_o(rrd), .periph_rdata_o(xrd));

  initial begin
    forever #12.5 ck = ~ck;
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge ck) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      $display("[ERR] %0t run did not finish", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ck);
    #1;
  endtask

  // one bus cycle; on a read d is the expected data
  task automatic acc(input bit pm, input bit wr, input logic [13:0] a,
                     input logic [23:0] d);
    @(posedge ck);
    pa  <= a;
    da  <= a;
    pwd <= d;
    dwd <= d[15:0];
    pw  <= pm & wr;
    pr  <= pm & !wr;
    dw  <= !pm & wr;
    dr  <= !pm & !wr;
    @(posedge ck);
    {pw, pr, dw, dr} <= 4'h0;
    #1;
    if (!wr)
      chk(pm ? prd : 24'(drd), d);
  endtask

  task automatic por_wait();
    int n;
    n = 0;
    while (srst !== 1'b0 && n < 200) begin
      step(1);
      n++;
    end
    chk(24'(n >= 2 * HOLD - 2 && n <= 2 * HOLD + 2), 24'h1);
    chk(24'(fst), 24'h1);
    chk(24'(fad), 24'(dsp_glue_pkg::BOOT_ADDR));
  endtask

  task automatic t_regs();
    acc(0, 0, dsp_glue_pkg::WAIT_ADDR, 24'hFFFF);
    acc(0, 0, dsp_glue_pkg::SYS_CTL_ADDR, 24'h0);
    @(posedge ck);
    spa <= 1'b0;
    step(1);
    chk(24'({eia, eib, spen}), 24'h4);
    acc(0, 1, dsp_glue_pkg::SYS_CTL_ADDR, 24'h0400);
    chk(24'({eia, eib, spen}), 24'h1);
    acc(0, 1, dsp_glue_pkg::WAIT_ADDR, 24'h8000);
    acc(0, 0, dsp_glue_pkg::WAIT_ADDR, 24'h8000);
    acc(0, 0, 14'h3C10, 24'h0);
    acc(0, 1, dsp_glue_pkg::MODE_CTL_ADDR, 24'h1);
    @(posedge ck);
    rxb <= 1'b1;
    step(1);
    chk(24'(rxo), 24'h1);
    acc(0, 1, dsp_glue_pkg::MODE_CTL_ADDR, 24'h0);
    chk(24'(rxo), 24'h0);
  endtask

  task automatic t_mem();
    acc(0, 1, 14'h3800, 24'hA5A5);
    acc(0, 1, 14'h39FF, 24'h5A5A);
    acc(0, 1, 14'h3A00, 24'hFFFF);
    acc(0, 0, 14'h3800, 24'hA5A5);
    acc(0, 0, 14'h39FF, 24'h5A5A);
    acc(0, 0, 14'h3A00, 24'h0);
    acc(1, 1, 14'h0000, 24'h12_3456);
    acc(1, 1, 14'h01FF, 24'hAB_CDEF);
    acc(1, 1, 14'h0200, 24'h11_1111);
    acc(1, 0, 14'h0000, 24'h12_3456);
    acc(1, 0, 14'h01FF, 24'hAB_CDEF);
    acc(1, 0, 14'h0200, 24'h0);
    acc(1, 0, 14'h0800, 24'h5A_3000);
    acc(1, 0, 14'h17FF, 24'h5A_3FFF);
    acc(1, 0, 14'h1800, 24'h0);
    acc(0, 0, 14'h2005, 24'hC305);
    acc(0, 0, 14'h20FF, 24'hC3FF);
    acc(0, 0, 14'h2100, 24'h0);
    // peripheral write strobe, address and data pass straight through
    @(posedge ck);
    da  <= 14'h2010;
    dwd <= 16'hBEEF;
    dw  <= 1'b1;
    #1;
    chk(24'({xw, xa}), 24'h110);
    chk(24'(xwd), 24'hBEEF);
    @(posedge ck);
    dw <= 1'b0;
    #1;
    chk(24'(xw), 24'h0);
  endtask

  task automatic t_irq();
    acc(0, 0, dsp_glue_pkg::IRQ_MASK_ADDR, 24'h0);
    @(posedge ck);
    cirq <= 5'h01;
    pio  <= 9'h004;
    step(2);
    chk(24'({ireq, pirq}), 24'h0);
    acc(0, 1, dsp_glue_pkg::IRQ_MASK_ADDR, 24'hFFFF);
    step(1);
    chk(24'({ireq, pirq, iid}), 24'h30);
    @(posedge ck);
    cirq <= 5'h00;
    step(2);
    chk(24'({ireq, pirq, iid}), 24'h37);
    acc(0, 1, dsp_glue_pkg::IRQ_MASK_ADDR, 24'hFF7F);
    step(1);
    chk(24'({ireq, pirq}), 24'h0);
    @(posedge ck);
    pio   <= 9'h000;
    cirq  <= 5'h10;
    psync <= 1'b1;
    step(2);
    chk(24'({ireq, pirq, iid}), 24'h34);
    acc(0, 0, dsp_glue_pkg::IRQ_STAT_ADDR, 24'h4010);
    @(posedge ck);
    cirq  <= 5'h00;
    psync <= 1'b0;
    ptrip <= 1'b1;
    step(2);
    chk(24'({ireq, pirq, iid}), 24'h3F);
    @(posedge ck);
    ptrip <= 1'b0;
  endtask

  task automatic t_clock();
    logic a;
    @(posedge ck);
    cke <= 1'b1;
    step(2);
    a = ico;
    step(1);
    chk(24'(ico), 24'(!a));
    @(posedge ck);
    cke <= 1'b0;
    step(2);
    chk(24'(ico), 24'h0);
  endtask

  task automatic t_resets();
    @(posedge ck);
    pin_n <= 1'b0;
    step(2);
    chk(24'({srst, stk, msc, fst}), 24'hE);
    @(posedge ck);
    pin_n <= 1'b1;
    step(2);
    chk(24'(srst), 24'h0);
    acc(0, 0, dsp_glue_pkg::WAIT_ADDR, 24'hFFFF);
    acc(0, 0, dsp_glue_pkg::IRQ_MASK_ADDR, 24'h0);
    acc(0, 0, dsp_glue_pkg::SYS_CTL_ADDR, 24'h0);
    @(posedge ck);
    sup <= 1'b0;
    step(2);
    chk(24'(srst), 24'h1);
    acc(0, 1, dsp_glue_pkg::WAIT_ADDR, 24'h1234);
    @(posedge ck);
    sup <= 1'b1;
    por_wait();
    acc(0, 0, dsp_glue_pkg::WAIT_ADDR, 24'hFFFF);
    // serial port now off: both pins act as the two lowest sources
    acc(0, 1, dsp_glue_pkg::IRQ_MASK_ADDR, 24'hFFFF);
    @(posedge ck);
    spb <= 1'b0;
    step(2);
    chk(24'({ireq, pirq, iid}), 24'h20);
    acc(0, 0, dsp_glue_pkg::IRQ_STAT_ADDR, 24'h0003);
  endtask

  initial begin
    repeat (5) @(posedge ck);
    #1;
    chk(24'({srst, stk, msc, fst}), 24'hE);
    @(posedge ck);
    rst <= 1'b0;
    por_wait();
    t_regs();
    t_mem();
    t_irq();
    t_clock();
    t_resets();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
